// file: shared/gtc_pkg.sv
// package of register map, field layout and codes for the count-clock front end
package gtc_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STCTRL = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_CNT = 8'h24;
  localparam logic [7:0] OFF_DIV = 8'h28;
  localparam logic [7:0] OFF_PR = 8'h2C;
  // control register fields
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_DIR_BIT = 4;
  localparam int CTRL_MODE_LSB = 5;
  localparam int CTRL_WIDE_BIT = 7;
  localparam int CTRL_APB1_BIT = 8;
  // slave control register fields
  localparam int ST_SMS_LSB = 0;
  localparam int ST_TSEL_LSB = 4;
  localparam int ST_FLT_LSB = 8;
  localparam int ST_EDIV_LSB = 12;
  localparam int ST_MODEB_BIT = 14;
  localparam int ST_POL_BIT = 15;
  // status register fields
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_DIR_BIT = 1;
  // codes
  localparam logic [2:0] SMS_EXT_A = 3'h7;
  localparam logic [2:0] TSEL_CH1_BOTH = 3'h4;
  localparam logic [2:0] TSEL_CH1_FP = 3'h5;
  localparam logic [2:0] TSEL_CH2_FP = 3'h6;
  localparam logic [2:0] TSEL_OUTSIDE = 3'h7;
  localparam logic [1:0] MODE_ONE_DIR = 2'h0;
  localparam int NUM_TRIG = 7;
  localparam int CH1_BOTH_IDX = 4;
  // reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [15:0] RST_DIV = 16'h0000;
endpackage

// file: shared/gtc_cond_if.sv
// link between the main block and the outside pin conditioner
`timescale 1ns/100ps
`default_nettype none
interface gtc_cond_if;
  logic pin_level;
  logic polarity;
  logic [1:0] divider;
  logic [3:0] filter;
  logic tick;
  modport ctl (output pin_level, output polarity, output divider, output filter, input tick);
  modport cond (input pin_level, input polarity, input divider, input filter, output tick);
endinterface
`default_nettype wire

// file: hw/gtc_pin_cond.sv
// outside clock pin conditioner: synchroniser, polarity, division, filter, tick
`timescale 1ns/100ps
`default_nettype none
module gtc_pin_cond (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // conditioning link
  gtc_cond_if.cond link
);
  logic sync1;
  logic sync2;
  logic pol_prev;
  logic [2:0] edge_cnt;
  logic div_lvl;
  logic filt_lvl;
  logic filt_prev;
  logic [3:0] filt_cnt;
  logic pol_lvl;

  assign pol_lvl = sync2 ^ link.polarity;

  // two stages: the first is read only by the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= link.pin_level;
      sync2 <= sync1;
    end
  end

  // divider counts polarised rising edges; a counter bit is the divided level, except divider 0 which passes the polarised level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_prev <= 1'b0;
      edge_cnt <= 3'h0;
    end else begin
      pol_prev <= pol_lvl;
      if (pol_lvl && !pol_prev) begin
        edge_cnt <= edge_cnt + 3'h1;
      end
    end
  end

  always_comb begin
    case (link.divider)
      2'h0: div_lvl = pol_lvl;
      2'h1: div_lvl = edge_cnt[0];
      2'h2: div_lvl = edge_cnt[1];
      default: div_lvl = edge_cnt[2];
    endcase
  end

  // a new level is accepted only after it has held for filter+1 samples
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_lvl <= 1'b0;
      filt_cnt <= 4'h0;
    end else if (div_lvl == filt_lvl) begin
      filt_cnt <= 4'h0;
    end else if (filt_cnt >= link.filter) begin
      filt_lvl <= div_lvl;
      filt_cnt <= 4'h0;
    end else begin
      filt_cnt <= filt_cnt + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_prev <= 1'b0;
      link.tick <= 1'b0;
    end else begin
      filt_prev <= filt_lvl;
      link.tick <= filt_lvl && !filt_prev;
    end
  end
endmodule
`default_nettype wire

// file: hw/gtc_timer_front.sv
// count-clock selection, prescaler and counter of a general-purpose timer
// Functional notes
// - tick rate is kernel clock over divider+1
// - sixteen-bit prescaler makes the counter tick
// - new divider applies only at next overflow
// - counter counts up, down or alternately
// - counter widens to 32 bits where supported
// - clock from bus, external modes or trigger
// - bus clock doubles unless bus prescaler one
// - slave mode 111 selects external mode A
// - trigger codes 4-7 pick channel or pin
// - mode B clocks from conditioned outside pin
// - external inputs synchronised before counting
// - another timer's trigger may clock this one
// - trigger codes 0-3 pick inner triggers
// - inner trigger wiring depends on slave timer
// - absent source timers leave trigger inactive
// - effective run follows run enable by one
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module gtc_timer_front #(
  parameter int SLAVE_TIMER = 2,
  parameter bit WIDE_CAPABLE = 1'b1,
  parameter bit HAS_TIMER15 = 1'b1
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // clock sources
  input wire logic outside_clock_pin,
  input wire logic ch1_both_edge_signal,
  input wire logic ch1_filtered_polarized,
  input wire logic ch2_filtered_polarized,
  input wire logic trig_timer1,
  input wire logic trig_timer2,
  input wire logic trig_timer3,
  input wire logic trig_timer15,
  input wire logic usb_sof,
  // state
  output logic effective_run_signal,
  output logic counter_tick_clock,
  output logic overflow_event,
  output logic [31:0] count_value
);
  logic counter_run_enable;
  logic count_direction;
  logic [1:0] count_mode_select;
  logic wide_enable;
  logic apb_div_is_one;
  logic [2:0] slave_mode_select;
  logic [2:0] trigger_source_select;
  logic [3:0] outside_pin_filter;
  logic [1:0] outside_pin_divider;
  logic mode_b_clock_enable;
  logic outside_pin_polarity;
  logic [15:0] div_reg;
  logic [15:0] div_active;
  logic [15:0] presc_cnt;
  logic [31:0] period_value;
  logic [31:0] pr_eff;
  logic [31:0] next_cnt;
  logic next_dir;
  logic next_ovf;
  logic bus_phase;
  logic bus_tick;
  logic src_tick;
  logic slave_trigger_input;
  logic [3:0] inner_trigger_n;
  logic [gtc_pkg::NUM_TRIG-1:0] trig_raw;
  logic [gtc_pkg::NUM_TRIG-1:0] trig_s1;
  logic [gtc_pkg::NUM_TRIG-1:0] trig_s2;
  logic [gtc_pkg::NUM_TRIG-1:0] trig_s3;
  logic [gtc_pkg::NUM_TRIG-1:0] trig_edge;
  logic wr_en;
  logic rd_setup;
  logic mapped;
  logic cnt_write;
  logic [31:0] rd_mux;
  logic [31:0] ctrl_view;
  logic [31:0] stctrl_view;

  gtc_cond_if cond_link ();

  assign cond_link.pin_level = outside_clock_pin;
  assign cond_link.polarity = outside_pin_polarity;
  assign cond_link.divider = outside_pin_divider;
  assign cond_link.filter = outside_pin_filter;

  gtc_pin_cond u_pin_cond (
    .pclk(pclk),
    .presetn(presetn),
    .link(cond_link)
  );

  // ---------------- apb slave ----------------
  assign mapped = (paddr == gtc_pkg::OFF_CTRL) || (paddr == gtc_pkg::OFF_STCTRL) ||
                  (paddr == gtc_pkg::OFF_STATUS) || (paddr == gtc_pkg::OFF_CNT) ||
                  (paddr == gtc_pkg::OFF_DIV) || (paddr == gtc_pkg::OFF_PR);
  assign wr_en = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  assign cnt_write = wr_en && (paddr == gtc_pkg::OFF_CNT);
  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    ctrl_view = gtc_pkg::RST_ZERO;
    ctrl_view[gtc_pkg::CTRL_RUN_BIT] = counter_run_enable;
    ctrl_view[gtc_pkg::CTRL_DIR_BIT] = count_direction;
    ctrl_view[gtc_pkg::CTRL_MODE_LSB +: 2] = count_mode_select;
    ctrl_view[gtc_pkg::CTRL_WIDE_BIT] = wide_enable;
    ctrl_view[gtc_pkg::CTRL_APB1_BIT] = apb_div_is_one;
    stctrl_view = gtc_pkg::RST_ZERO;
    stctrl_view[gtc_pkg::ST_SMS_LSB +: 3] = slave_mode_select;
    stctrl_view[gtc_pkg::ST_TSEL_LSB +: 3] = trigger_source_select;
    stctrl_view[gtc_pkg::ST_FLT_LSB +: 4] = outside_pin_filter;
    stctrl_view[gtc_pkg::ST_EDIV_LSB +: 2] = outside_pin_divider;
    stctrl_view[gtc_pkg::ST_MODEB_BIT] = mode_b_clock_enable;
    stctrl_view[gtc_pkg::ST_POL_BIT] = outside_pin_polarity;
    case (paddr)
      gtc_pkg::OFF_CTRL: rd_mux = ctrl_view;
      gtc_pkg::OFF_STCTRL: rd_mux = stctrl_view;
      gtc_pkg::OFF_STATUS: begin
        rd_mux = gtc_pkg::RST_ZERO;
        rd_mux[gtc_pkg::STAT_RUN_BIT] = effective_run_signal;
        rd_mux[gtc_pkg::STAT_DIR_BIT] = count_direction;
      end
      gtc_pkg::OFF_CNT: rd_mux = count_value;
      gtc_pkg::OFF_DIV: rd_mux = {16'h0000, div_reg};
      gtc_pkg::OFF_PR: rd_mux = period_value;
      default: rd_mux = gtc_pkg::RST_ZERO;
    endcase
  end

  // read data is captured in the setup cycle and stands through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= gtc_pkg::RST_ZERO;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_run_enable <= 1'b0;
      count_mode_select <= gtc_pkg::MODE_ONE_DIR;
      wide_enable <= 1'b0;
      apb_div_is_one <= 1'b0;
    end else if (wr_en && paddr == gtc_pkg::OFF_CTRL) begin
      counter_run_enable <= pwdata[gtc_pkg::CTRL_RUN_BIT];
      count_mode_select <= pwdata[gtc_pkg::CTRL_MODE_LSB +: 2];
      wide_enable <= pwdata[gtc_pkg::CTRL_WIDE_BIT] && WIDE_CAPABLE;
      apb_div_is_one <= pwdata[gtc_pkg::CTRL_APB1_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slave_mode_select <= 3'h0;
      trigger_source_select <= 3'h0;
      outside_pin_filter <= 4'h0;
      outside_pin_divider <= 2'h0;
      mode_b_clock_enable <= 1'b0;
      outside_pin_polarity <= 1'b0;
    end else if (wr_en && paddr == gtc_pkg::OFF_STCTRL) begin
      slave_mode_select <= pwdata[gtc_pkg::ST_SMS_LSB +: 3];
      trigger_source_select <= pwdata[gtc_pkg::ST_TSEL_LSB +: 3];
      outside_pin_filter <= pwdata[gtc_pkg::ST_FLT_LSB +: 4];
      outside_pin_divider <= pwdata[gtc_pkg::ST_EDIV_LSB +: 2];
      mode_b_clock_enable <= pwdata[gtc_pkg::ST_MODEB_BIT];
      outside_pin_polarity <= pwdata[gtc_pkg::ST_POL_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= gtc_pkg::RST_DIV;
      period_value <= gtc_pkg::RST_ZERO;
    end else if (wr_en && paddr == gtc_pkg::OFF_DIV) begin
      div_reg <= pwdata[15:0];
    end else if (wr_en && paddr == gtc_pkg::OFF_PR) begin
      period_value <= WIDE_CAPABLE ? pwdata : {16'h0000, pwdata[15:0]};
    end
  end

  // ---------------- clock sources ----------------
  // pclk is the doubled kernel rate; with a bus prescaler of one only every other edge counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_phase <= 1'b0;
    end else begin
      bus_phase <= !bus_phase;
    end
  end
  assign bus_tick = apb_div_is_one ? bus_phase : 1'b1;

  // inner trigger wiring; a missing source timer is tied inactive
  assign inner_trigger_n[0] = trig_timer1;
  assign inner_trigger_n[1] = (SLAVE_TIMER == 2) ? (trig_timer15 && HAS_TIMER15) : trig_timer2;
  assign inner_trigger_n[2] = (SLAVE_TIMER == 2) ? trig_timer3 : (trig_timer15 && HAS_TIMER15);
  assign inner_trigger_n[3] = (SLAVE_TIMER == 2) ? usb_sof : 1'b0;

  assign trig_raw = {ch2_filtered_polarized, ch1_filtered_polarized, ch1_both_edge_signal, inner_trigger_n};

  // edges are taken between stages two and three, never from stage one
  genvar gi;
  generate
    for (gi = 0; gi < gtc_pkg::NUM_TRIG; gi++) begin : g_trig_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          trig_s1[gi] <= 1'b0;
          trig_s2[gi] <= 1'b0;
          trig_s3[gi] <= 1'b0;
        end else begin
          trig_s1[gi] <= trig_raw[gi];
          trig_s2[gi] <= trig_s1[gi];
          trig_s3[gi] <= trig_s2[gi];
        end
      end
      if (gi == gtc_pkg::CH1_BOTH_IDX) begin : g_both
        assign trig_edge[gi] = trig_s2[gi] ^ trig_s3[gi];
      end else begin : g_rise
        assign trig_edge[gi] = trig_s2[gi] && !trig_s3[gi];
      end
    end
  endgenerate

  always_comb begin
    case (trigger_source_select)
      gtc_pkg::TSEL_CH1_BOTH: slave_trigger_input = trig_edge[gtc_pkg::CH1_BOTH_IDX];
      gtc_pkg::TSEL_CH1_FP: slave_trigger_input = trig_edge[gtc_pkg::CH1_BOTH_IDX + 1];
      gtc_pkg::TSEL_CH2_FP: slave_trigger_input = trig_edge[gtc_pkg::CH1_BOTH_IDX + 2];
      gtc_pkg::TSEL_OUTSIDE: slave_trigger_input = cond_link.tick;
      default: slave_trigger_input = trig_edge[trigger_source_select[1:0]];
    endcase
  end

  // mode B takes precedence, then mode A, else the bus-derived clock
  always_comb begin
    if (mode_b_clock_enable) begin
      src_tick = cond_link.tick;
    end else if (slave_mode_select == gtc_pkg::SMS_EXT_A) begin
      src_tick = slave_trigger_input;
    end else begin
      src_tick = bus_tick;
    end
  end

  // ---------------- run enable, prescaler, counter ----------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      effective_run_signal <= 1'b0;
    end else begin
      effective_run_signal <= counter_run_enable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_cnt <= 16'h0000;
    end else if (cnt_write) begin
      presc_cnt <= 16'h0000;
    end else if (effective_run_signal && src_tick) begin
      presc_cnt <= (presc_cnt >= div_active) ? 16'h0000 : presc_cnt + 16'h0001;
    end
  end
  assign counter_tick_clock = effective_run_signal && src_tick && (presc_cnt >= div_active);

  // the shadow divider only moves on an overflow, so a mid-period write cannot glitch the ratio
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_active <= gtc_pkg::RST_DIV;
    end else if (overflow_event) begin
      div_active <= div_reg;
    end
  end

  assign pr_eff = wide_enable ? period_value : {16'h0000, period_value[15:0]};

  always_comb begin
    next_cnt = count_value;
    next_dir = count_direction;
    next_ovf = 1'b0;
    if (count_mode_select == gtc_pkg::MODE_ONE_DIR) begin
      if (!count_direction) begin
        next_ovf = (count_value >= pr_eff);
        next_cnt = next_ovf ? gtc_pkg::RST_ZERO : count_value + 32'h0000_0001;
      end else begin
        next_ovf = (count_value == gtc_pkg::RST_ZERO);
        next_cnt = next_ovf ? pr_eff : count_value - 32'h0000_0001;
      end
    end else if (!count_direction) begin
      next_ovf = (count_value >= pr_eff - 32'h0000_0001);
      next_cnt = next_ovf ? pr_eff : count_value + 32'h0000_0001;
      next_dir = next_ovf;
    end else begin
      // clamp at the ends so a stale direction left by one-direction mode cannot wrap the count
      next_ovf = (count_value <= 32'h0000_0001);
      next_cnt = next_ovf ? gtc_pkg::RST_ZERO : count_value - 32'h0000_0001;
      next_dir = !next_ovf;
    end
    if (!wide_enable) begin
      next_cnt = {16'h0000, next_cnt[15:0]};
    end
  end

  // a zero period halts the counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value <= gtc_pkg::RST_ZERO;
      count_direction <= 1'b0;
      overflow_event <= 1'b0;
    end else begin
      overflow_event <= 1'b0;
      if (cnt_write) begin
        count_value <= wide_enable ? pwdata : {16'h0000, pwdata[15:0]};
      end else if (counter_tick_clock && pr_eff != gtc_pkg::RST_ZERO) begin
        count_value <= next_cnt;
        count_direction <= next_dir;
        overflow_event <= next_ovf;
      end
      // direction is software-owned only in one-direction mode
      if (wr_en && paddr == gtc_pkg::OFF_CTRL && pwdata[gtc_pkg::CTRL_MODE_LSB +: 2] == gtc_pkg::MODE_ONE_DIR) begin
        count_direction <= pwdata[gtc_pkg::CTRL_DIR_BIT];
      end
    end
  end

  // ---------------- assertions ----------------
  a_run_lag: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(counter_run_enable) |=> effective_run_signal ##0 $past(effective_run_signal) == 1'b0)
    else $error("effective run did not follow run enable by one cycle");
  a_div_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !overflow_event |=> div_active == $past(div_active))
    else $error("divider shadow changed without overflow");
  a_div_load: assert property (@(posedge pclk) disable iff (!presetn)
    overflow_event |=> div_active == $past(div_reg))
    else $error("divider shadow not loaded at overflow");
  a_tick_ratio: assert property (@(posedge pclk) disable iff (!presetn)
    counter_tick_clock |-> presc_cnt == div_active && effective_run_signal)
    else $error("counter tick not at divider terminal count");
  a_up_step: assert property (@(posedge pclk) disable iff (!presetn)
    counter_tick_clock && !cnt_write && count_mode_select == gtc_pkg::MODE_ONE_DIR && !count_direction
    && count_value < pr_eff |=> count_value == $past(count_value) + 32'h0000_0001)
    else $error("up count did not advance by one");
  a_idle_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !counter_tick_clock && !cnt_write |=> count_value == $past(count_value))
    else $error("counter moved without a tick");
  a_mode_b_src: assert property (@(posedge pclk) disable iff (!presetn)
    mode_b_clock_enable |-> src_tick == cond_link.tick)
    else $error("mode b not clocked from outside pin");
  a_bus_src: assert property (@(posedge pclk) disable iff (!presetn)
    !mode_b_clock_enable && slave_mode_select != gtc_pkg::SMS_EXT_A |-> src_tick == bus_tick)
    else $error("bus clock not selected by default");
  a_bus_rate: assert property (@(posedge pclk) disable iff (!presetn)
    apb_div_is_one && $past(apb_div_is_one) |-> bus_tick != $past(bus_tick))
    else $error("bus clock rate wrong with prescaler one");
  a_ch1_sel: assert property (@(posedge pclk) disable iff (!presetn)
    !mode_b_clock_enable && slave_mode_select == gtc_pkg::SMS_EXT_A
    && trigger_source_select == gtc_pkg::TSEL_CH1_FP |-> src_tick == trig_edge[gtc_pkg::CH1_BOTH_IDX + 1])
    else $error("channel one filtered trigger not selected");
  c_mode_a: cover property (@(posedge pclk) disable iff (!presetn)
    slave_mode_select == gtc_pkg::SMS_EXT_A && counter_tick_clock);
  c_mode_b: cover property (@(posedge pclk) disable iff (!presetn)
    mode_b_clock_enable && counter_tick_clock);
  c_turn: cover property (@(posedge pclk) disable iff (!presetn)
    count_mode_select != gtc_pkg::MODE_ONE_DIR && $rose(count_direction));
  c_reload: cover property (@(posedge pclk) disable iff (!presetn)
    overflow_event && div_reg != div_active);
endmodule
`default_nettype wire

// file: verif/gtc_src_model.sv
// model of the far-side clock sources: other timers' trigger outputs, channel signals and the outside pin
`timescale 1ns/100ps
`default_nettype none
module gtc_src_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // command
  input wire logic start,
  input wire logic [3:0] sel,
  input wire logic [3:0] rises,
  // source lines, line 8 is a decoy toggled alongside
  output logic [8:0] lines,
  output logic done
);
  logic [7:0] left;
  logic [2:0] pace;
  // slow edges, one toggle every 8 cycles, so the pin filter and synchronisers see clean levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lines <= 9'h000;
      left <= 8'h00;
      pace <= 3'h0;
    end else if (start) begin
      left <= {3'h0, rises, 1'b0};
      pace <= 3'h0;
    end else if (left != 8'h00) begin
      pace <= pace + 3'h1;
      if (pace == 3'h7) begin
        lines[sel] <= ~lines[sel];
        lines[8] <= ~lines[8];
        left <= left - 8'h01;
      end
    end
  end
  assign done = (left == 8'h00);
endmodule
`default_nettype wire

// file: verif/tb_gp_timer_count_clock_select.sv
// self-checking bench of the count-clock front end over apb
`timescale 1ns/100ps
`default_nettype none
module tb_gp_timer_count_clock_select;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, eff, tick, ovf, start, done, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, cv, q;
  logic [8:0] lines;
  logic [3:0] sel, rises;
  int errors, cmp_count, cyc, g;
  localparam logic [7:0] REGS [6] = '{gtc_pkg::OFF_CTRL, gtc_pkg::OFF_STCTRL, gtc_pkg::OFF_STATUS,
    gtc_pkg::OFF_CNT, gtc_pkg::OFF_DIV, gtc_pkg::OFF_PR};
  gtc_timer_front dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .outside_clock_pin(lines[7]), .ch1_both_edge_signal(lines[4]), .ch1_filtered_polarized(lines[5]),
    .ch2_filtered_polarized(lines[6]), .trig_timer1(lines[0]), .trig_timer2(lines[8]), .trig_timer3(lines[2]),
    .trig_timer15(lines[1]), .usb_sof(lines[3]), .effective_run_signal(eff), .counter_tick_clock(tick),
    .overflow_event(ovf), .count_value(cv));
  gtc_src_model src_u (.pclk(pclk), .presetn(presetn), .start(start), .sel(sel), .rises(rises),
    .lines(lines), .done(done));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task stop_test;
    if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      stop_test();
    end
  end
  // request held from setup until pready is seen high at a rising edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask
  function automatic logic sig(input int w);
    return (w == 0) ? tick : ovf;
  endfunction
  task wait_sig(input int w);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (sig(w) !== 1'b1 && n < 300);
  endtask
  task gap(input int w);
    wait_sig(w);
    g = 0;
    do begin
      @(posedge pclk);
      g++;
    end while (sig(w) !== 1'b1 && g < 300);
  endtask
  // run bit goes last so the source is fully conditioned before counting starts
  task setup(input logic [31:0] c, input logic [31:0] st, input logic [31:0] d, input logic [31:0] p,
    input logic [31:0] n0);
    apb(1'b1, gtc_pkg::OFF_CTRL, c);
    apb(1'b1, gtc_pkg::OFF_STCTRL, st);
    apb(1'b1, gtc_pkg::OFF_DIV, d);
    apb(1'b1, gtc_pkg::OFF_PR, p);
    apb(1'b1, gtc_pkg::OFF_CNT, n0);
    apb(1'b1, gtc_pkg::OFF_CTRL, c | 32'h0000_0001);
    #1 chk({31'h0, eff}, 32'h0000_0000);
    @(posedge pclk);
    #1 chk({31'h0, eff}, 32'h0000_0001);
  endtask
  task pulses(input int s, input int n);
    int k;
    k = 0;
    @(posedge pclk);
    start <= 1'b1;
    sel <= 4'(s);
    rises <= 4'(n);
    @(posedge pclk);
    start <= 1'b0;
    do begin
      @(posedge pclk);
      k++;
    end while (done !== 1'b1 && k < 300);
    // covers the synchroniser and filter latency of the last edge
    repeat (12) @(posedge pclk);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    start = 1'b0;
    sel = 4'h0;
    rises = 4'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) rd_chk(REGS[i], gtc_pkg::RST_ZERO);
    rd_chk(8'h04, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    for (int t = 0; t < 8; t++) begin
      setup(32'h0000_0000, 32'(t) << 4 | 32'h0000_0007, 32'h0000_0000, 32'h0000_00FF, 32'h0000_0000);
      pulses(t, 3);
      rd_chk(gtc_pkg::OFF_CNT, (t == 4) ? 32'h0000_0006 : 32'h0000_0003);
    end
    setup(32'h0000_0000, 32'h0000_5000, 32'h0000_0000, 32'h0000_00FF, 32'h0000_0000);
    pulses(7, 4);
    rd_chk(gtc_pkg::OFF_CNT, 32'h0000_0002);
    // widest pin filter rejects the model's eight-cycle levels, so nothing is counted
    setup(32'h0000_0000, 32'h0000_4F00, 32'h0000_0000, 32'h0000_00FF, 32'h0000_0000);
    pulses(7, 3);
    rd_chk(gtc_pkg::OFF_CNT, 32'h0000_0000);
    setup(32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0005, 32'h0000_0000);
    gap(1);
    chk(32'(g), 32'h0000_0006);
    setup(32'h0000_0010, 32'h0000_0000, 32'h0000_0000, 32'h0000_0005, 32'h0000_0000);
    gap(1);
    chk(32'(g), 32'h0000_0006);
    rd_chk(gtc_pkg::OFF_STATUS, 32'h0000_0003);
    setup(32'h0000_0020, 32'h0000_0000, 32'h0000_0000, 32'h0000_0005, 32'h0000_0000);
    gap(1);
    chk(32'(g), 32'h0000_0005);
    setup(32'h0000_0100, 32'h0000_0000, 32'h0000_0000, 32'h0000_00FF, 32'h0000_0000);
    gap(0);
    chk(32'(g), 32'h0000_0002);
    setup(32'h0000_0080, 32'h0000_0000, 32'h0000_0000, 32'h0001_0002, 32'h0000_FFFF);
    wait_sig(0);
    #1 chk(cv, 32'h0001_0000);
    setup(32'h0000_0000, 32'h0000_0000, 32'h0000_0003, 32'h0000_0007, 32'h0000_0000);
    gap(0);
    chk(32'(g), 32'h0000_0001);
    wait_sig(1);
    gap(0);
    chk(32'(g), 32'h0000_0004);
    stop_test();
  end
endmodule
`default_nettype wire
